// ---- logic/pmbs_seq.sv ----
// Purpose: Start-up and power mode sequencer of a low-energy radio controller
// Assumes: i_mclk runs free from an always-on source; analog status on pins
// Notes:   Waits are typical times; xtal ready must also be seen
//
// Function
// - At power-up run RC oscillator first, clocking the supply check.
// - Enable crystal only after supply good; switch to crystal after startup.
// - On crystal clock reaching logic, enter idle and send idle event.
// - Power mode follows chip state only; host cannot pick it directly.
// - Standby: crystal runs as main clock, RC oscillator also active.
// - Retention: crystal stopped, RC running, logic supply lowered, state kept.
// - Off: all oscillators stopped, logic supply lowered, state kept.
// - Power-up to standby takes typically 15.5 ms.
// - Back to standby: 2.6 ms from retention, 2.7 ms from off in UART mode; SPI wake from off goes to retention first.
// - Idle is the default state after any reset completes.
// - Host reset pin held at least 5 ms reboots device, then idle event.
// - UART: wake pin high restarts oscillators, enters idle, sends event.
// - Sleep chip state uses the retention power mode.
`timescale 1ns/1ps
`include "pmbs_defs.svh"

module pmbs_seq #(
  parameter int P_T_STARTUP_CYC = `PMBS_T_STARTUP_US * `PMBS_MCLK_MHZ,
  parameter int P_T_SLEEP_CYC   = `PMBS_T_SLEEP_US * `PMBS_MCLK_MHZ,
  parameter int P_T_OFF_CYC     = `PMBS_T_OFF_US * `PMBS_MCLK_MHZ,
  parameter int P_T_HRST_CYC    = `PMBS_T_HRST_US * `PMBS_MCLK_MHZ
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_reset,
  input  wire logic                    i_supply_ok,
  input  wire logic                    i_xtal_ready,
  input  wire logic                    i_sel_spi,
  input  wire logic                    i_wake_request_pin,
  input  wire logic                    i_host_rst_pin,
  input  wire logic                    i_sleep_req,
  input  wire logic                    i_off_req,
  input  wire logic                    i_spi_wake,
  input  wire logic                    i_evt_ack,
  output logic                         o_chk_clk_en,
  output pmbs_pkg::pmbs_osc_t          o_osc,
  output pmbs_pkg::pmbs_pmode_t        o_power_mode,
  output logic                         o_evt_valid,
  output logic [`PMBS_EVT_W-1:0]       o_evt_code,
  output logic                         o_evt_spi
);
  import pmbs_pkg::*;

  localparam logic [`PMBS_CNT_W-1:0] C_STARTUP = P_T_STARTUP_CYC[`PMBS_CNT_W-1:0];
  localparam logic [`PMBS_CNT_W-1:0] C_SLEEP   = P_T_SLEEP_CYC[`PMBS_CNT_W-1:0];
  localparam logic [`PMBS_CNT_W-1:0] C_OFF     = P_T_OFF_CYC[`PMBS_CNT_W-1:0];
  localparam logic [`PMBS_CNT_W-1:0] C_HRST    = P_T_HRST_CYC[`PMBS_CNT_W-1:0];

  // ==========================================================
  // Input synchronisers
  logic [`PMBS_NSYNC-1:0] sy;
  logic                   sup_ok;
  logic                   xtal_rdy;
  logic                   sel_spi;
  logic                   wake;
  logic                   hrst;

  pmbs_sync u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async ({i_host_rst_pin, i_wake_request_pin, i_sel_spi, i_xtal_ready, i_supply_ok}),
    .o_level (sy)
  );

  assign sup_ok   = sy[`PMBS_SY_SUPPLY];
  assign xtal_rdy = sy[`PMBS_SY_XTAL];
  assign sel_spi  = sy[`PMBS_SY_SEL];
  assign wake     = sy[`PMBS_SY_WAKE];
  assign hrst     = sy[`PMBS_SY_HRST];

  // ==========================================================
  // Sequencer state
  pmbs_state_t                 state_r;
  pmbs_state_t                 state_nxt;
  logic [`PMBS_CNT_W-1:0]      cnt_r;
  logic [`PMBS_CNT_W-1:0]      cnt_nxt;
  logic [`PMBS_CNT_W-1:0]      budget_r;
  logic [`PMBS_CNT_W-1:0]      budget_nxt;
  logic [`PMBS_CNT_W-1:0]      hcnt_r;
  logic [`PMBS_CNT_W-1:0]      hcnt_nxt;
  logic [`PMBS_DIV_W-1:0]      div_r;
  logic [`PMBS_DIV_W-1:0]      div_nxt;
  logic                        wake_r;
  logic                        wake_rise;
  logic                        xtal_stable;
  logic                        chk_nxt;
  pmbs_osc_t                   osc_nxt;
  pmbs_pmode_t                 pm_nxt;
  logic                        evt_nxt;
  logic [`PMBS_EVT_W-1:0]      code_nxt;
  logic                        spi_nxt;

  assign wake_rise   = wake && !wake_r;
  assign xtal_stable = xtal_rdy && (cnt_r >= budget_r);

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = (cnt_r == C_STARTUP) ? cnt_r : cnt_r + `PMBS_CNT_ONE;
    budget_nxt = budget_r;
    hcnt_nxt   = hrst ? ((hcnt_r == C_HRST) ? hcnt_r : hcnt_r + `PMBS_CNT_ONE)
                      : `PMBS_CNT_ZERO;
    div_nxt    = `PMBS_DIV_ZERO;
    evt_nxt    = o_evt_valid && !i_evt_ack;
    code_nxt   = o_evt_code;
    spi_nxt    = o_evt_spi;
    unique case (state_r)
      S_RC_START: begin
        state_nxt  = S_SUPPLY_CHK;
        budget_nxt = C_STARTUP;
      end
      S_SUPPLY_CHK: begin
        div_nxt = div_r + `PMBS_DIV_ONE;
        if (sup_ok) begin
          state_nxt = S_XTAL_WAIT;
        end
      end
      S_XTAL_WAIT: begin
        if (xtal_stable) begin
          state_nxt = S_IDLE;
          evt_nxt   = 1'b1;
          code_nxt  = `PMBS_EVT_IDLE;
          spi_nxt   = sel_spi;
        end
      end
      S_IDLE: begin
        if (i_off_req) begin
          state_nxt = S_OFF;
        end else if (i_sleep_req) begin
          state_nxt = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if ((!sel_spi && wake_rise) || (sel_spi && i_spi_wake)) begin
          state_nxt  = S_XTAL_WAIT;
          cnt_nxt    = `PMBS_CNT_ZERO;
          budget_nxt = C_SLEEP;
        end
      end
      S_OFF: begin
        if (!sel_spi && wake_rise) begin
          state_nxt  = S_XTAL_WAIT;
          cnt_nxt    = `PMBS_CNT_ZERO;
          budget_nxt = C_OFF;
        end else if (sel_spi && i_spi_wake) begin
          state_nxt = S_SLEEP;
        end
      end
      S_HOST_RST: begin
        evt_nxt = 1'b0;
        if (!hrst) begin
          state_nxt = S_RC_START;
          cnt_nxt   = `PMBS_CNT_ZERO;
        end
      end
    endcase
    if (hrst && hcnt_r == C_HRST) begin
      state_nxt = S_HOST_RST;
      cnt_nxt   = `PMBS_CNT_ZERO;
    end
    chk_nxt = (state_nxt == S_SUPPLY_CHK) && (div_nxt == `PMBS_DIV_LAST);
    // Power mode derived from state alone
    osc_nxt = '0;
    pm_nxt  = PM_BOOT;
    unique case (state_nxt)
      S_RC_START, S_SUPPLY_CHK: begin
        osc_nxt.rc_en = 1'b1;
        pm_nxt        = PM_BOOT;
      end
      S_XTAL_WAIT: begin
        osc_nxt.rc_en   = 1'b1;
        osc_nxt.xtal_en = 1'b1;
        pm_nxt          = PM_BOOT;
      end
      S_IDLE: begin
        osc_nxt = '{rc_en: 1'b1, xtal_en: 1'b1, clk_xtal: 1'b1, main_en: 1'b1,
                    logic_vlow: 1'b0};
        pm_nxt  = PM_STANDBY;
      end
      S_SLEEP: begin
        osc_nxt.rc_en      = 1'b1;
        osc_nxt.logic_vlow = 1'b1;
        pm_nxt             = PM_RETENTION;
      end
      S_OFF, S_HOST_RST: begin
        osc_nxt.logic_vlow = 1'b1;
        pm_nxt             = PM_OFF;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_r      <= S_RC_START;
      cnt_r        <= `PMBS_CNT_ZERO;
      budget_r     <= `PMBS_CNT_ZERO;
      hcnt_r       <= `PMBS_CNT_ZERO;
      div_r        <= `PMBS_DIV_ZERO;
      wake_r       <= 1'b0;
      o_chk_clk_en <= 1'b0;
      o_osc        <= '0;
      o_power_mode <= PM_BOOT;
      o_evt_valid  <= 1'b0;
      o_evt_code   <= `PMBS_EVT_NONE;
      o_evt_spi    <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      budget_r     <= budget_nxt;
      hcnt_r       <= hcnt_nxt;
      div_r        <= div_nxt;
      wake_r       <= wake;
      o_chk_clk_en <= chk_nxt;
      o_osc        <= osc_nxt;
      o_power_mode <= pm_nxt;
      o_evt_valid  <= evt_nxt;
      o_evt_code   <= code_nxt;
      o_evt_spi    <= spi_nxt;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence boot_done_s;
    state_r == S_XTAL_WAIT && xtal_stable && !(hrst && hcnt_r == C_HRST);
  endsequence

  sequence sleep_wake_s;
    state_r == S_SLEEP && !sel_spi && wake_rise && !(hrst && hcnt_r == C_HRST);
  endsequence

  rc_first_a: assert property ((state_r == S_SUPPLY_CHK) |-> o_osc.rc_en && !o_osc.xtal_en)
    else $error("RC not alone during supply check");
  xtal_gate_a: assert property ((state_r == S_SUPPLY_CHK && !sup_ok) |=> !o_osc.xtal_en)
    else $error("Crystal enabled before supply good");
  idle_event_a: assert property (boot_done_s |=> o_evt_valid && o_evt_code == `PMBS_EVT_IDLE
                                 && o_osc.clk_xtal && o_power_mode == PM_STANDBY)
    else $error("No idle event on crystal handover");
  main_hold_a: assert property ($rose(o_osc.main_en) |-> $past(xtal_stable)
                               && o_osc.clk_xtal && o_osc.xtal_en)
    else $error("Main logic active without crystal");
  standby_osc_a: assert property ((o_power_mode == PM_STANDBY) |-> o_osc.xtal_en
                                  && o_osc.rc_en && !o_osc.logic_vlow)
    else $error("Standby oscillators wrong");
  retention_a: assert property ((state_r == S_SLEEP) |-> o_power_mode == PM_RETENTION
                                && !o_osc.xtal_en && o_osc.rc_en && o_osc.logic_vlow)
    else $error("Sleep not in retention mode");
  off_mode_a: assert property ((o_power_mode == PM_OFF) |-> !o_osc.rc_en && !o_osc.xtal_en
                               && o_osc.logic_vlow)
    else $error("Off mode oscillators running");
  budget_wait_a: assert property ((state_r == S_XTAL_WAIT && cnt_r < budget_r)
                                  |=> !o_osc.main_en)
    else $error("Crystal declared before its wait");
  hrst_filter_a: assert property (($rose(state_r == S_HOST_RST)) |-> $past(hcnt_r) == C_HRST)
    else $error("Host reset taken before hold time");
  uart_wake_a: assert property (sleep_wake_s |=> state_r == S_XTAL_WAIT && budget_r == C_SLEEP
                                ##0 o_osc.xtal_en)
    else $error("Wake pin did not restart crystal");

endmodule

// ---- logic/pmbs_sync.sv ----
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_mclk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
`include "pmbs_defs.svh"

module pmbs_sync (
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset,
  input  wire logic [`PMBS_NSYNC-1:0]   i_async,
  output logic      [`PMBS_NSYNC-1:0]   o_level
);
  import pmbs_pkg::*;

  logic [`PMBS_NSYNC-1:0] ff1_r;
  logic [`PMBS_NSYNC-1:0] ff2_r;
  logic [`PMBS_NSYNC-1:0] ff3_r;
  logic [`PMBS_NSYNC-1:0] lvl_nxt;

  genvar g;
  generate
    for (g = 0; g < `PMBS_NSYNC; g++) begin : g_bit
      always_comb begin
        lvl_nxt[g] = (ff2_r[g] == ff3_r[g]) ? ff3_r[g] : o_level[g];
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ff1_r   <= `PMBS_SY_ZERO;
      ff2_r   <= `PMBS_SY_ZERO;
      ff3_r   <= `PMBS_SY_ZERO;
      o_level <= `PMBS_SY_ZERO;
    end else begin
      ff1_r   <= i_async;
      ff2_r   <= ff1_r;
      ff3_r   <= ff2_r;
      o_level <= lvl_nxt;
    end
  end

endmodule

// ---- shared/pmbs_defs.svh ----
// Purpose: Timing figures, counter widths and codes of the boot sequencer
// Assumes: Master clock of 250 MHz
// Notes:   Cycle counts derive from the times below
`ifndef PMBS_DEFS_SVH
`define PMBS_DEFS_SVH

// ==========================================================
// Clock and times
`define PMBS_MCLK_MHZ     250
`define PMBS_T_STARTUP_US 15500
`define PMBS_T_SLEEP_US   2600
`define PMBS_T_OFF_US     2700
`define PMBS_T_HRST_US    5000

// ==========================================================
// Counters
`define PMBS_CNT_W        22
`define PMBS_CNT_ZERO     22'h000000
`define PMBS_CNT_ONE      22'h000001
`define PMBS_DIV_W        4
`define PMBS_DIV_ZERO     4'h0
`define PMBS_DIV_ONE      4'h1
`define PMBS_DIV_LAST     4'hF

// ==========================================================
// Synchroniser lanes
`define PMBS_NSYNC        5
`define PMBS_SY_SUPPLY    0
`define PMBS_SY_XTAL      1
`define PMBS_SY_SEL       2
`define PMBS_SY_WAKE      3
`define PMBS_SY_HRST      4
`define PMBS_SY_ZERO      5'h00

// ==========================================================
// Event codes
`define PMBS_EVT_W        8
`define PMBS_EVT_NONE     8'h00
`define PMBS_EVT_IDLE     8'h01

`endif

// ---- shared/pmbs_pkg.sv ----
// Purpose: Types of the power mode boot sequencer
// Assumes: Included after pmbs_defs.svh
// Notes:   States and power modes carry no explicit codes
package pmbs_pkg;

  typedef enum logic [2:0] {
    S_RC_START,
    S_SUPPLY_CHK,
    S_XTAL_WAIT,
    S_IDLE,
    S_SLEEP,
    S_OFF,
    S_HOST_RST
  } pmbs_state_t;

  typedef enum logic [1:0] {
    PM_BOOT,
    PM_STANDBY,
    PM_RETENTION,
    PM_OFF
  } pmbs_pmode_t;

  typedef struct packed {
    logic rc_en;
    logic xtal_en;
    logic clk_xtal;
    logic main_en;
    logic logic_vlow;
  } pmbs_osc_t;

endpackage

// ---- sim/pmbs_host_model.sv ----
// Purpose: Host controller model that takes sequencer events
// Assumes: Events arrive as a valid level with a code
// Notes:   Acknowledges after one or six cycles
`timescale 1ns/1ps
`include "pmbs_defs.svh"

module pmbs_host_model (
  input  wire logic                   i_mclk,
  input  wire logic                   i_evt_valid,
  input  wire logic [`PMBS_EVT_W-1:0] i_evt_code,
  input  wire logic                   i_slow,
  output logic                        o_evt_ack,
  output int                          o_events
);
  int wait_r;

  // ==========================================
  // Event intake
  initial begin
    o_evt_ack = 1'b0;
    o_events  = 0;
    wait_r    = 0;
  end

  always @(negedge i_mclk) begin
    o_evt_ack <= 1'b0;
    if (i_evt_valid === 1'b1 && o_evt_ack !== 1'b1) begin
      if (wait_r >= (i_slow ? 6 : 1)) begin
        o_evt_ack <= 1'b1;
        // Corrupted code not counted, host would reset again
        o_events  <= o_events + ((i_evt_code === `PMBS_EVT_IDLE) ? 1 : 0);
        wait_r    <= 0;
      end else begin
        wait_r <= wait_r + 1;
      end
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench of the boot sequencer
// Assumes: Shortened wait counts
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`include "pmbs_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t got %0h exp %0h", $time, (a), (b)); end end

module testbench;
  import pmbs_pkg::*;
  localparam int T_UP = 40;
  localparam int T_SL = 20;
  localparam int T_OF = 25;
  logic        clk, rst, sup, sel, wake, hrst, slp, off, spiw, slow, chk_en, ev_v, ev_s, ack;
  logic        xrdy = 1'b0;
  logic [7:0]  ev_c;
  pmbs_osc_t   osc;
  pmbs_pmode_t pm;
  int          errors, n_checks, cyc, nevt;
  int          xcnt = 0;

  pmbs_seq #(.P_T_STARTUP_CYC(T_UP), .P_T_SLEEP_CYC(T_SL), .P_T_OFF_CYC(T_OF),
    .P_T_HRST_CYC(10)) pmbs_seq_i (.i_mclk(clk), .i_reset(rst), .i_supply_ok(sup),
    .i_xtal_ready(xrdy), .i_sel_spi(sel), .i_wake_request_pin(wake), .i_host_rst_pin(hrst),
    .i_sleep_req(slp), .i_off_req(off), .i_spi_wake(spiw), .i_evt_ack(ack),
    .o_chk_clk_en(chk_en), .o_osc(osc), .o_power_mode(pm), .o_evt_valid(ev_v),
    .o_evt_code(ev_c), .o_evt_spi(ev_s));

  pmbs_host_model pmbs_host_model_i (.i_mclk(clk), .i_evt_valid(ev_v), .i_evt_code(ev_c),
    .i_slow(slow), .o_evt_ack(ack), .o_events(nevt));

  // ==========================================
  // Clock, crystal startup model, timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(negedge clk) begin
    xcnt <= (osc.xtal_en === 1'b1) ? ((xcnt < 8) ? xcnt + 1 : xcnt) : 0;
    xrdy <= (xcnt == 8);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_evt(output int n);
    int m;
    n = 0;
    m = 0;
    while (ev_v !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    `CHK(ev_v, 1'b1)
    `CHK(osc, 5'h1E)
    `CHK(pm, PM_STANDBY)
    `CHK(ev_c, `PMBS_EVT_IDLE)
    `CHK(ev_s, sel)
    while (ev_v === 1'b1 && m < 20) begin
      step(1);
      m++;
    end
    `CHK(ev_v, 1'b0)
    `CHK(m, slow ? 7 : 2)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_boot();
    int p, n;
    p = 0;
    rst = 1'b1;
    step(8);
    rst = 1'b0;
    repeat (20) begin
      step(1);
      p += int'(chk_en === 1'b1);
    end
    `CHK(osc, 5'h10)
    `CHK(p >= 1, 1'b1)
    sup = 1'b1;
    step(8);
    `CHK(osc, 5'h18)
    wait_evt(n);
    `CHK(n + 28 >= T_UP && n + 28 <= T_UP + 3, 1'b1)
  endtask

  task automatic t_lp(input logic is_off);
    int n;
    int b;
    b = is_off ? T_OF : T_SL;
    // Off request must win over a sleep request raised with it
    off = is_off;
    slp = 1'b1;
    step(1);
    off = 1'b0;
    slp = 1'b0;
    step(1);
    `CHK(pm, is_off ? PM_OFF : PM_RETENTION)
    `CHK(osc, is_off ? 5'h01 : 5'h11)
    spiw = 1'b1;
    step(1);
    spiw = 1'b0;
    step(6);
    `CHK(pm, is_off ? PM_OFF : PM_RETENTION)
    wake = 1'b1;
    wait_evt(n);
    `CHK(n >= b + 4 && n <= b + 7, 1'b1)
    wake = 1'b0;
  endtask

  task automatic t_spi();
    int n;
    // Short host reset pulse must be ignored
    hrst = 1'b1;
    step(6);
    hrst = 1'b0;
    step(8);
    `CHK(pm, PM_STANDBY)
    `CHK(ev_v, 1'b0)
    sel = 1'b1;
    slow = 1'b1;
    hrst = 1'b1;
    step(20);
    `CHK(pm, PM_OFF)
    `CHK(osc, 5'h01)
    hrst = 1'b0;
    wait_evt(n);
    `CHK(n >= T_UP && n <= T_UP + 8, 1'b1)
    off = 1'b1;
    step(1);
    off = 1'b0;
    wake = 1'b1;
    slp = 1'b1;
    step(10);
    `CHK(pm, PM_OFF)
    wake = 1'b0;
    slp = 1'b0;
    spiw = 1'b1;
    step(1);
    spiw = 1'b0;
    step(1);
    `CHK(pm, PM_RETENTION)
    spiw = 1'b1;
    step(1);
    spiw = 1'b0;
    wait_evt(n);
    `CHK(nevt, 5)
  endtask

  initial begin
    {rst, sup, sel, wake, hrst, slp, off, spiw, slow} = 9'h100;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    t_boot();
    $display("boot test done");
    t_lp(1'b0);
    $display("sleep test done");
    t_lp(1'b1);
    $display("off test done");
    t_spi();
    $display("host reset and spi test done");
    report_and_stop();
  end
endmodule
